// File: bench/pb_power_ctrl_asserts.sv
// Checker for the pushbutton power controller ports.
`timescale 1ns/1ns
`default_nettype none
module pb_power_ctrl_chk #(parameter int ON_CYC = 8, INT_CYC = 8, RST_CYC = 12, ENA_LOW = 0) (
   input wire clk_i,
   input wire rst_n_i,
   input wire button_n_i,
   input wire kill_n_i,
   input wire undervoltage_lockout_in_n_i,
   input wire low_supply_sense_in_n_i,
   input wire supply_good_i,
   input wire enable_o,
   input wire off_int_n_o,
   input wire low_supply_warning_out_n_o,
   input wire sys_reset_n_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Power state seen through the enable polarity of the bound instance.
   logic pwr;
   assign pwr = (ENA_LOW != 0) ? ~enable_o : enable_o;
   int lo_c;
   always @(posedge clk_i or negedge rst_n_i)
      if (!rst_n_i) lo_c <= 0;
      else lo_c <= off_int_n_o ? 0 : lo_c + 1;
   property p_on; $rose(pwr) |-> !$past(button_n_i, ON_CYC); endproperty
   a_on: assert property (p_on) else $error("enable rose without full press");
   property p_int; $rose(off_int_n_o) |-> lo_c == INT_CYC; endproperty
   a_int: assert property (p_int) else $error("interrupt width wrong");
   property p_kill; pwr && $fell(kill_n_i) |=> !pwr; endproperty
   a_kill: assert property (p_kill) else $error("kill low kept power");
   property p_lock;
      !pwr && !undervoltage_lockout_in_n_i && !$past(undervoltage_lockout_in_n_i)
      |=> !pwr;
   endproperty
   a_lock: assert property (p_lock) else $error("power on in lockout");
   property p_warn; low_supply_warning_out_n_o == $past(low_supply_sense_in_n_i); endproperty
   a_warn: assert property (p_warn) else $error("warning not following sense");
   property p_rst; !supply_good_i |=> !sys_reset_n_o; endproperty
   a_rst: assert property (p_rst) else $error("reset out released early");
   property p_rrel; $rose(sys_reset_n_o) |-> $past(supply_good_i, RST_CYC); endproperty
   a_rrel: assert property (p_rrel) else $error("reset delay too short");
   property p_src;
      $fell(off_int_n_o) |-> $past(button_n_i) || !$past(undervoltage_lockout_in_n_i);
   endproperty
   a_src: assert property (p_src) else $error("interrupt without cause");
   cover property ($rose(pwr));
   cover property ($fell(off_int_n_o));
   cover property ($rose(sys_reset_n_o));
endmodule // pb_power_ctrl_chk
bind pb_power_ctrl pb_power_ctrl_chk #(.ON_CYC(ON_CYC), .INT_CYC(INT_CYC), .RST_CYC(RST_CYC),
   .ENA_LOW(ENABLE_ACTIVE_LOW))
   u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .button_n_i(button_n_i), .kill_n_i(kill_n_i),
   .undervoltage_lockout_in_n_i(undervoltage_lockout_in_n_i), .enable_o(enable_o),
   .low_supply_sense_in_n_i(low_supply_sense_in_n_i), .supply_good_i(supply_good_i),
   .off_int_n_o(off_int_n_o), .low_supply_warning_out_n_o(low_supply_warning_out_n_o),
   .sys_reset_n_o(sys_reset_n_o));
`default_nettype wire

// File: bench/sys_model.sv
// System logic model that grants power and answers the off request.
`timescale 1ns/1ns
`default_nettype none
module sys_model (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       en_i,
   input  wire logic       int_n_i,
   input  wire logic [1:0] md_i,
   output logic            kill_n_o
);
   // Mode 0 answers, mode 1 never raises kill, mode 2 ignores the interrupt.
   logic [3:0] c_r;
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i || !en_i) begin
         kill_n_o <= 1'b0;
         c_r      <= 4'h0;
      end else begin
         if (c_r != 4'hF) c_r <= c_r + 4'h1;
         if (c_r == 4'h3 && md_i != 2'h1) kill_n_o <= 1'b1;
         if (!int_n_i && md_i == 2'h0) kill_n_o <= 1'b0;
      end
   end
endmodule // sys_model
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking testbench for the pushbutton power controller.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam int ON = 8, KC = 40, IN = 8, FC = 16, UV = 8, RC = 12, PD = 4;
   logic clk_i, rst_n_i, btn, uv, ls, sg;
   logic [1:0] md;
   wire kill, en, intn, warn, srn, en_lo;
   int err_total, n_tests, i, k;
   pb_power_ctrl #(.ON_CYC(ON), .KILL_CYC(KC), .INT_CYC(IN), .FORCE_CYC(FC), .UNDERVOLTAGE_LOCKOUT_IN_CYC(UV),
      .RST_CYC(RC), .PDT_CYC(PD)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .button_n_i(btn),
      .kill_n_i(kill), .undervoltage_lockout_in_n_i(uv), .low_supply_sense_in_n_i(ls),
      .supply_good_i(sg), .enable_o(en), .off_int_n_o(intn),
      .low_supply_warning_out_n_o(warn), .sys_reset_n_o(srn));
   sys_model u_sys (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en), .int_n_i(intn), .md_i(md),
      .kill_n_o(kill));
   pb_power_ctrl #(.ENABLE_ACTIVE_LOW(1'b1), .ON_CYC(ON), .KILL_CYC(KC), .INT_CYC(IN),
      .FORCE_CYC(FC), .UNDERVOLTAGE_LOCKOUT_IN_CYC(UV), .RST_CYC(RC), .PDT_CYC(PD)) dut_lo (.clk_i(clk_i),
      .rst_n_i(rst_n_i), .button_n_i(btn), .kill_n_i(kill), .undervoltage_lockout_in_n_i(uv),
      .low_supply_sense_in_n_i(ls), .supply_good_i(sg), .enable_o(en_lo), .off_int_n_o(),
      .low_supply_warning_out_n_o(), .sys_reset_n_o());
   function int fp();
      return FC + PD;
   endfunction
   task end_of_test();
      $display("errors %0d checks %0d", err_total, n_tests);
      if (err_total == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task tk(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("MISMATCH %s exp %0h got %0h", s, e, g);
         err_total++;
      end
   endtask
   task wt(input int w, input logic v, input int mx);
      k = 0;
      while (((w == 0) ? en : (w == 1) ? intn : srn) !== v) begin
         if (k >= mx) begin
            $display("MISMATCH wait%0d exp %0d got %0d", w, mx, k);
            err_total++;
            end_of_test();
         end
         tk(1);
         k++;
      end
   endtask
   initial begin
      clk_i = 0;
      forever #20 clk_i = ~clk_i;
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      end_of_test();
   end
   initial begin
      btn = 1; uv = 1; ls = 1; sg = 0; md = 0; rst_n_i = 0; err_total = 0; n_tests = 0;
      k = $urandom(53053);
      tk(8); rst_n_i = 1; tk(2);
      uv = 0; btn = 0; tk(ON + 6);
      chk("en_lock", 0, en);
      btn = 1; uv = 1; tk(2);
      btn = 0; tk(ON - 2); btn = 1; tk(4);
      chk("en_short", 0, en);
      btn = 0; wt(0, 1, 40);
      chk("t_on", 1, k >= ON && k <= ON + 2);
      chk("en_lo_on", 0, en_lo);
      btn = 1; tk(KC + 4);
      chk("kill_ok", 1, en);
      for (i = 0; i < 4; i++) begin
         uv = 0; tk(1 + $urandom % (UV - 2)); uv = 1; tk(3);
         chk("glitch", 1, intn);
      end
      btn = 0; tk(3); btn = 1; wt(1, 0, 4); wt(1, 1, IN + 4);
      chk("int_w", IN, k);
      chk("kill_off", 0, en);
      chk("en_lo_off", 1, en_lo);
      md = 1; btn = 0; wt(0, 1, 40); btn = 1; wt(0, 0, KC + 8);
      chk("kill_to", 1, k >= KC - 2 && k <= KC + 2);
      md = 2; btn = 0; wt(0, 1, 40); btn = 1; tk(5); btn = 0; wt(0, 0, fp() + 8); btn = 1;
      chk("force", 1, k >= fp() && k <= fp() + 2);
      tk(2); btn = 0; wt(0, 1, 40); btn = 1; tk(6); uv = 0; wt(1, 0, UV + 4);
      chk("uv_int", 1, k >= UV && k <= UV + 2);
      wt(0, 0, 3 * UV + 8);
      chk("uv_off", 0, en);
      chk("uv_off_t", 1, k >= IN && k <= IN + 2);
      uv = 1; tk(2);
      for (i = 0; i < 32; i++) begin
         ls = 1'($urandom); tk(1);
         chk("warn", ls, warn);
      end
      sg = 1; wt(2, 1, RC + 6);
      chk("rst_dly", 1, k >= RC && k <= RC + 2);
      sg = 0; tk(2);
      chk("rst_low", 0, srn);
      end_of_test();
   end
endmodule // tb_top
`default_nettype wire

// File: hw/pb_ctrl_defines.vh
// Timing constants and encodings for the pushbutton power controller.
`ifndef PB_CTRL_DEFINES_VH
`define PB_CTRL_DEFINES_VH

`define CLK_HZ          25000000
`define ON_DEBOUNCE_MS  32
`define KILL_WAIT_MS    512
`define INT_PULSE_MS    32
`define FORCE_OFF_MS    64
`define UNDERVOLTAGE_LOCKOUT_IN_FILTER_MS  32
`define RESET_DELAY_MS  200

`define MS_CYCLES(ms)   ((ms) * (`CLK_HZ / 1000))

`define ST_OFF          3'h0
`define ST_WAIT_KILL    3'h1
`define ST_ON           3'h2
`define ST_INT          3'h3
`define ST_WAIT_OFF     3'h4

`endif

// File: hw/pb_power_ctrl.v
// Pushbutton on/off controller with undervoltage lockout and reset delay.
//
// How it works
// R1 - Enable after 32 ms unbroken press
// R2 - System raises kill input within 512 ms
// R3 - No kill high in window: power off
// R4 - Press and release pulses interrupt 32 ms
// R5 - System housekeeps, then drives kill low
// R6 - Kill low removes supply enable
// R7 - Hold 64 ms plus extra forces off
// R8 - Warning output follows low-supply sense
// R9 - Warning never affects enable or interrupt
// R10 - Undervoltage under 32 ms is ignored
// R11 - Long undervoltage pulses interrupt 32 ms
// R12 - Persisting undervoltage removes power
// R13 - Off and undervoltage: button ignored
// R14 - Reset held 200 ms after supply good
// R15 - Active-low enable variant polarity
`timescale 1ns/1ns
`default_nettype none
`include "pb_ctrl_defines.vh"

module pb_power_ctrl #(
   parameter        ENABLE_ACTIVE_LOW = 1'b0,
   parameter [27:0] ON_CYC    = `MS_CYCLES(`ON_DEBOUNCE_MS),
   parameter [27:0] KILL_CYC  = `MS_CYCLES(`KILL_WAIT_MS),
   parameter [27:0] INT_CYC   = `MS_CYCLES(`INT_PULSE_MS),
   parameter [27:0] FORCE_CYC = `MS_CYCLES(`FORCE_OFF_MS),
   parameter [27:0] UNDERVOLTAGE_LOCKOUT_IN_CYC  = `MS_CYCLES(`UNDERVOLTAGE_LOCKOUT_IN_FILTER_MS),
   parameter [27:0] RST_CYC   = `MS_CYCLES(`RESET_DELAY_MS),
   parameter [27:0] PDT_CYC   = 28'h0000000
) (
   input  wire clk_i,
   input  wire rst_n_i,
   input  wire button_n_i,
   input  wire kill_n_i,
   input  wire undervoltage_lockout_in_n_i,
   input  wire low_supply_sense_in_n_i,
   input  wire supply_good_i,
   output wire enable_o,
   output wire off_int_n_o,
   output wire low_supply_warning_out_n_o,
   output wire sys_reset_n_o
);

   localparam integer W = 28;

   //---------------------------------------------------------------------
   // State codes
   //---------------------------------------------------------------------
   localparam [2:0] S_OFF       = `ST_OFF;
   localparam [2:0] S_WAIT_KILL = `ST_WAIT_KILL;
   localparam [2:0] S_ON        = `ST_ON;
   localparam [2:0] S_INT       = `ST_INT;
   localparam [2:0] S_WAIT_OFF  = `ST_WAIT_OFF;

   //---------------------------------------------------------------------
   // Timer lengths
   //---------------------------------------------------------------------
   // A timer flags done in the cycle after its last counted edge, so each
   // length is one less than the number of edges the condition must last.
   localparam [W-1:0] ON_LEN    = ON_CYC - 28'h0000001;
   localparam [W-1:0] KILL_LEN  = KILL_CYC - 28'h0000001;
   localparam [W-1:0] INT_LEN   = INT_CYC - 28'h0000001;
   localparam [W-1:0] FORCE_LEN = FORCE_CYC + PDT_CYC - 28'h0000001;
   localparam [W-1:0] UV_LEN    = UNDERVOLTAGE_LOCKOUT_IN_CYC - 28'h0000001;
   localparam [W-1:0] RST_LEN   = RST_CYC - 28'h0000001;

   //---------------------------------------------------------------------
   // Registers and nets
   //---------------------------------------------------------------------
   reg  [2:0] state_r;
   reg  [2:0] state_nxt;
   reg        en_r;
   reg        int_n_r;
   reg        int_act_r;
   reg        warn_n_r;
   reg        rst_out_n_r;
   reg        btn_seen_r;
   reg        press_d_r;

   wire       press;
   wire       uv_low;
   wire       release_evt;
   wire       int_enter;
   wire       on_run;
   wire       kill_run;
   wire       int_run;
   wire       force_run;
   wire       uv_run;
   wire       rst_run;
   wire       on_done;
   wire       kill_tmo;
   wire       int_done;
   wire       force_done;
   wire       uv_done;
   wire       rst_done;

   //---------------------------------------------------------------------
   // Input levels
   //---------------------------------------------------------------------
   assign press  = ~button_n_i;
   assign uv_low = ~undervoltage_lockout_in_n_i;

   //---------------------------------------------------------------------
   // Timers
   //---------------------------------------------------------------------
   assign on_run    = (state_r == S_OFF) && press && !uv_low; // R1 R13
   assign kill_run  = (state_r == S_WAIT_KILL) && !kill_n_i; // R3
   assign int_run   = int_act_r; // R4 R11
   assign force_run = (state_r != S_OFF) && press; // R7
   assign uv_run    = en_r && uv_low; // R10
   assign rst_run   = supply_good_i; // R14

   pb_timer #(
      .WIDTH (W)
   ) u_on (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .run_i   (on_run),
      .len_i   (ON_LEN),
      .done_o  (on_done)
   );

   pb_timer #(
      .WIDTH (W)
   ) u_kill (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .run_i   (kill_run),
      .len_i   (KILL_LEN),
      .done_o  (kill_tmo)
   );

   pb_timer #(
      .WIDTH (W)
   ) u_int (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .run_i   (int_run),
      .len_i   (INT_LEN),
      .done_o  (int_done)
   );

   pb_timer #(
      .WIDTH (W)
   ) u_force (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .run_i   (force_run),
      .len_i   (FORCE_LEN),
      .done_o  (force_done)
   );

   pb_timer #(
      .WIDTH (W)
   ) u_uv (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .run_i   (uv_run),
      .len_i   (UV_LEN),
      .done_o  (uv_done)
   );

   pb_timer #(
      .WIDTH (W)
   ) u_rst (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .run_i   (rst_run),
      .len_i   (RST_LEN),
      .done_o  (rst_done)
   );

   //---------------------------------------------------------------------
   // Button tracking
   //---------------------------------------------------------------------
   // The press that turned power on must be released before a new press
   // can count as an off request.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         btn_seen_r <= 1'b0;
      end else if (state_r == S_OFF) begin
         btn_seen_r <= 1'b0;
      end else if (!press) begin
         btn_seen_r <= 1'b1;
      end
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         press_d_r <= 1'b0;
      end else begin
         press_d_r <= press;
      end
   end

   assign release_evt = btn_seen_r && press_d_r && !press;

   //---------------------------------------------------------------------
   // Interrupt pulse
   //---------------------------------------------------------------------
   // The pulse runs its full width even when the system answers early and
   // power is removed while it is still low.
   assign int_enter = (state_nxt == S_INT) && (state_r != S_INT);

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         int_act_r <= 1'b0;
      end else if (int_enter) begin
         int_act_r <= 1'b1;
      end else if (int_done) begin
         int_act_r <= 1'b0;
      end
   end

   //---------------------------------------------------------------------
   // Power state machine
   //---------------------------------------------------------------------
   always @* begin
      state_nxt = state_r;
      case (state_r)
         S_OFF: begin
            if (on_done) begin
               state_nxt = S_WAIT_KILL; // R1
            end
         end
         S_WAIT_KILL: begin
            if (kill_n_i) begin
               state_nxt = S_ON; // R2
            end else if (kill_tmo) begin
               state_nxt = S_OFF; // R3
            end
         end
         S_ON: begin
            if (release_evt || uv_done) begin
               state_nxt = S_INT; // R4 R11
            end
         end
         S_INT: begin
            if (int_done) begin
               state_nxt = S_WAIT_OFF;
            end
         end
         S_WAIT_OFF: begin
            if (release_evt) begin
               state_nxt = S_INT; // R4
            end
         end
         default: begin
            state_nxt = S_OFF;
         end
      endcase
      // Kill low after power-up approval, forced hold, or lasting undervoltage.
      if ((state_r != S_OFF) && (state_r != S_WAIT_KILL) && !kill_n_i) begin
         state_nxt = S_OFF; // R5 R6
      end
      if (force_done) begin
         state_nxt = S_OFF; // R7
      end
      if (uv_done && ((state_r == S_WAIT_OFF) || (state_r == S_WAIT_KILL))) begin
         state_nxt = S_OFF; // R12
      end
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r     <= S_OFF;
         en_r        <= 1'b0;
         int_n_r     <= 1'b1;
         warn_n_r    <= 1'b1;
         rst_out_n_r <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         en_r        <= (state_nxt != S_OFF);
         int_n_r     <= !(int_enter || (int_act_r && !int_done)); // R4 R11
         warn_n_r    <= low_supply_sense_in_n_i; // R8 R9
         rst_out_n_r <= rst_done; // R14
      end
   end

   //---------------------------------------------------------------------
   // Outputs
   //---------------------------------------------------------------------
   assign enable_o                   = ENABLE_ACTIVE_LOW ? ~en_r : en_r; // R15
   assign off_int_n_o                = int_n_r;
   assign low_supply_warning_out_n_o = warn_n_r;
   assign sys_reset_n_o              = rst_out_n_r;

endmodule // pb_power_ctrl

`default_nettype wire

// File: hw/pb_timer.v
// Restartable up-counter that flags when a run has lasted its full length.
`timescale 1ns/1ns
`default_nettype none

module pb_timer #(
   parameter integer WIDTH = 24
) (
   input  wire             clk_i,
   input  wire             rst_n_i,
   input  wire             run_i,
   input  wire [WIDTH-1:0] len_i,
   output wire             done_o
);

   reg [WIDTH-1:0] cnt_r;

   // The count restarts whenever run drops, so only an unbroken run expires.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r <= {WIDTH{1'b0}};
      end else if (!run_i) begin
         cnt_r <= {WIDTH{1'b0}};
      end else if (cnt_r != len_i) begin
         cnt_r <= cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   assign done_o = run_i && (cnt_r == len_i);

endmodule // pb_timer

`default_nettype wire
